// ==== rtl/drss_sequencer.sv ====
// start/stop sequencer with frequency ramp for a motor drive
// assumes a plain register port on the same clock and pins from outside
//
// Contract
// - start at startup frequency, hold, then accelerate
// - target below startup frequency: stay in standby
// - skip hold on reversal; hold counts as running
// - direct start: timed startup dc braking
// - pre-excitation start: timed field build, zero skips
// - startup current scaled to device rated current
// - stop mode 0: decelerate to zero, stop
// - stop mode 1: cut output at once
// - stop braking begins at braking start frequency
// - output suppressed for wait before stop braking
// - stop braking current scaled to motor rating
// - stop braking held; zero time skips it
// - brake usage only with built-in braking unit
// - ramp mode 0/1/2 for start and stop
// - linear slope, four time sets from terminals
// - S-curve A slope rises, flat, falls to a floor of one
// - S-curve B time law above rated frequency
//
// The placing of the registers and strobed register access were decided locally.
`include "drss_map.svh"
`timescale 1ns/1ns
`default_nettype none
module drss_sequencer #(
  parameter int TICK_CYCLES = `DRSS_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic [1:0] rampSelPin,
  input wire logic brakeUnitPin,
  output logic [15:0] outFreq,
  output logic outEnable,
  output logic outReverse,
  output logic dcBrakeOn,
  output logic preExciteOn,
  output logic [15:0] dcCurrent,
  output logic [15:0] brakeDuty,
  output logic standby,
  output logic runActive
);

  // scale by percent (1 %) or per mille (0.1 %) without a divider
  function automatic logic [19:0] pctOf(input logic [19:0] v, input logic [15:0] p, input logic tenth);
    logic [57:0] prod;
    prod = {38'h0, v} * {42'h0, p} * (tenth ? 58'd4194 : 58'd41943);
    return prod[41:22];
  endfunction

  // 0.1 s setting to control ticks
  function automatic logic [19:0] dsTicks(input logic [15:0] v);
    logic [31:0] p;
    p = {16'h0000, v} * `DRSS_TICKS_PER_DS;
    return p[19:0];
  endfunction

  function automatic drss_pkg::drss_word_t cfgDefault(input int i);
    case (i)
      `DRSS_START_FREQ: cfgDefault = `DRSS_DEF_START_FREQ;
      `DRSS_STOP_PCT: cfgDefault = `DRSS_DEF_STOP_PCT;
      `DRSS_BRAKE_USE: cfgDefault = `DRSS_DEF_BRAKE_USE;
      `DRSS_S_START, `DRSS_S_END: cfgDefault = `DRSS_DEF_S_RATIO;
      `DRSS_MAX_FREQ, `DRSS_RATED_FREQ: cfgDefault = `DRSS_DEF_FREQ;
      `DRSS_DEV_CUR, `DRSS_MOT_CUR: cfgDefault = `DRSS_DEF_CUR;
      default: cfgDefault = (i >= `DRSS_ACC0) ? `DRSS_DEF_RAMP_TIME : 16'h0000;
    endcase
  endfunction

  logic rstMeta;
  logic rstSync;
  logic [1:0] selMeta;
  logic [1:0] selSync;
  logic unitMeta;
  logic unitSync;
  logic [20:0] tickCnt_reg;
  logic tick;
  drss_pkg::drss_word_t cfg [0:`DRSS_CFG_N-1];
  drss_pkg::drss_state_e state_reg;
  logic [19:0] timer_reg;
  logic [47:0] rampErr_reg;
  logic [8:0] slopeLvl_reg;
  logic [23:0] slopeAcc_reg;

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // terminal and strap pins are asynchronous: two flops each
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      selMeta <= 2'h0;
      selSync <= 2'h0;
      unitMeta <= 1'b0;
      unitSync <= 1'b0;
    end else if (clkEn) begin
      selMeta <= rampSelPin;
      selSync <= selMeta;
      unitMeta <= brakeUnitPin;
      unitSync <= unitMeta;
    end
  end

  // control tick prescaler
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      tickCnt_reg <= 21'h0;
    end else if (clkEn) begin
      tickCnt_reg <= tick ? 21'h0 : tickCnt_reg + 21'h1;
    end
  end
  assign tick = (tickCnt_reg == 21'(TICK_CYCLES - 1));

  // configuration words, written by index
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      for (int i = 0; i < `DRSS_CFG_N; i++) begin
        cfg[i] <= cfgDefault(i);
      end
    end else if (clkEn && regWr && regAddr <= `DRSS_LAST_CFG) begin
      cfg[regAddr] <= regWrData;
    end
  end

  // decoded settings
  logic runCmd;
  logic revCmd;
  logic preMode;
  logic coastMode;
  logic [1:0] rampMode;
  logic [15:0] maxF;
  logic [15:0] ratedF;
  logic [15:0] startF;
  logic [15:0] tgtClamp;
  assign runCmd = cfg[`DRSS_CTRL][`DRSS_CTRL_RUN];
  assign revCmd = cfg[`DRSS_CTRL][`DRSS_CTRL_REV];
  assign preMode = cfg[`DRSS_CTRL][`DRSS_CTRL_PREEX];
  assign coastMode = cfg[`DRSS_CTRL][`DRSS_CTRL_COAST];
  assign rampMode = cfg[`DRSS_CTRL][`DRSS_CTRL_RAMP_LO +: 2];
  assign maxF = cfg[`DRSS_MAX_FREQ];
  assign ratedF = cfg[`DRSS_RATED_FREQ];
  // startup frequency is deliberately not clipped to any lower limit
  assign startF = cfg[`DRSS_START_FREQ];
  assign tgtClamp = (cfg[`DRSS_TARGET] > maxF) ? maxF : cfg[`DRSS_TARGET];

  // ramp target and direction
  logic running;
  logic dirChange;
  logic [15:0] rampTgt;
  logic rampUp;
  logic rampOn;
  logic [15:0] remain;
  assign running = (state_reg == drss_pkg::ST_RUN) || (state_reg == drss_pkg::ST_DECEL);
  assign dirChange = (revCmd != outReverse);
  assign rampTgt = (state_reg == drss_pkg::ST_RUN && !dirChange) ? tgtClamp : 16'h0000;
  assign rampUp = (outFreq < rampTgt);
  assign rampOn = running && (outFreq != rampTgt);
  assign remain = rampUp ? rampTgt - outFreq : outFreq - rampTgt;

  // time set chosen by terminals; accel when rising, decel when falling
  logic [15:0] rampTime;
  logic [19:0] rampTicks;
  assign rampTime = rampUp ? cfg[`DRSS_ACC0 + {3'h0, selSync}] : cfg[`DRSS_DEC0 + {3'h0, selSync}];
  assign rampTicks = (dsTicks(rampTime) == 20'h0) ? 20'h1 : dsTicks(rampTime);

  // per tick the error grows by num; each cycle one step drains den.
  // slope is num/den in 0.01 Hz per tick
  logic [47:0] num;
  logic [47:0] den;
  logic stepNow;
  always_comb begin
    num = {39'h0, `DRSS_SLOPE_FULL} * {32'h0, maxF};
    den = {28'h0, rampTicks} * {39'h0, `DRSS_SLOPE_FULL};
    case (rampMode)
      `DRSS_RAMP_SA: begin
        num = {39'h0, slopeLvl_reg} * {32'h0, maxF};
      end
      `DRSS_RAMP_SB: begin
        // below rated: fb per T; above: slope 9 fb^2 / (8 f T)
        num = {44'h0, 4'h9} * {32'h0, ratedF} * {32'h0, ratedF};
        if (outFreq > ratedF) begin
          den = {44'h0, 4'h8} * {32'h0, outFreq} * {28'h0, rampTicks};
        end else begin
          den = {44'h0, 4'h9} * {32'h0, ratedF} * {28'h0, rampTicks};
        end
      end
      default: begin
      end
    endcase
    if (den == 48'h0) begin
      den = 48'h1;
    end
  end
  assign stepNow = rampOn && (rampErr_reg >= den);

  // ramp error accumulator, cleared whenever the ramp is at rest
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      rampErr_reg <= 48'h0;
    end else if (clkEn) begin
      if (!rampOn) begin
        rampErr_reg <= 48'h0;
      end else begin
        rampErr_reg <= rampErr_reg + (tick ? num : 48'h0) - (stepNow ? den : 48'h0);
      end
    end
  end

  // S-curve A segment lengths; end distance is area under falling slope
  logic [19:0] segStart;
  logic [19:0] segEnd;
  logic [19:0] endDist;
  logic inEnd;
  logic [19:0] segT;
  logic slopeDrain;
  assign segStart = pctOf(rampTicks, cfg[`DRSS_S_START], 1'b1);
  assign segEnd = pctOf(rampTicks, cfg[`DRSS_S_END], 1'b1);
  // segments would overlap if the ratios summed past full scale
  assign endDist = pctOf({4'h0, maxF}, cfg[`DRSS_S_END], 1'b1) >> 1;
  assign inEnd = (segEnd != 20'h0) && ({4'h0, remain} <= endDist);
  assign segT = inEnd ? segEnd : segStart;
  assign slopeDrain = (segT != 20'h0) && (slopeAcc_reg >= {4'h0, segT});

  // slope level: rises in start segment, flat, falls near the end.
  // floor of one keeps the ramp converging at the cost of a slow tail
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      slopeLvl_reg <= 9'h001;
      slopeAcc_reg <= 24'h0;
    end else if (clkEn) begin
      if (!rampOn) begin
        slopeLvl_reg <= (segStart == 20'h0) ? `DRSS_SLOPE_FULL : 9'h001;
        slopeAcc_reg <= 24'h0;
      end else if (segT == 20'h0) begin
        slopeLvl_reg <= `DRSS_SLOPE_FULL;
      end else begin
        slopeAcc_reg <= slopeAcc_reg + (tick ? 24'h100 : 24'h0) - (slopeDrain ? {4'h0, segT} : 24'h0);
        if (slopeDrain && inEnd && slopeLvl_reg > 9'h001) begin
          slopeLvl_reg <= slopeLvl_reg - 9'h001;
        end else if (slopeDrain && !inEnd && slopeLvl_reg < `DRSS_SLOPE_FULL) begin
          slopeLvl_reg <= slopeLvl_reg + 9'h001;
        end
      end
    end
  end

  // start/stop sequence, frequency and drive outputs
  logic timerDone;
  logic [19:0] startCur;
  logic [19:0] stopCur;
  assign timerDone = (timer_reg == 20'h0);
  assign startCur = pctOf({4'h0, cfg[`DRSS_DEV_CUR]}, cfg[`DRSS_START_PCT], 1'b0);
  assign stopCur = pctOf({4'h0, cfg[`DRSS_MOT_CUR]}, cfg[`DRSS_STOP_PCT], 1'b0);

  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      state_reg <= drss_pkg::ST_STOP;
      outFreq <= 16'h0000;
      outEnable <= 1'b0;
      outReverse <= 1'b0;
      dcBrakeOn <= 1'b0;
      preExciteOn <= 1'b0;
      dcCurrent <= 16'h0000;
      standby <= 1'b0;
      timer_reg <= 20'h0;
    end else if (clkEn) begin
      if (tick && !timerDone) begin
        timer_reg <= timer_reg - 20'h1;
      end
      case (state_reg)
        drss_pkg::ST_STOP: begin
          outFreq <= 16'h0000;
          outEnable <= 1'b0;
          dcBrakeOn <= 1'b0;
          preExciteOn <= 1'b0;
          standby <= runCmd && (tgtClamp < startF);
          if (runCmd && tgtClamp >= startF) begin
            outReverse <= revCmd;
            timer_reg <= dsTicks(cfg[`DRSS_START_TIME]);
            dcCurrent <= startCur[15:0];
            if (cfg[`DRSS_START_TIME] == 16'h0000) begin
              outFreq <= startF;
              outEnable <= 1'b1;
              timer_reg <= dsTicks(cfg[`DRSS_HOLD_TIME]);
              state_reg <= drss_pkg::ST_HOLD;
            end else begin
              dcBrakeOn <= !preMode;
              preExciteOn <= preMode;
              state_reg <= drss_pkg::ST_STARTDC;
            end
          end
        end
        drss_pkg::ST_STARTDC: begin
          if (!runCmd) begin
            dcBrakeOn <= 1'b0;
            preExciteOn <= 1'b0;
            state_reg <= drss_pkg::ST_STOP;
          end else if (timerDone) begin
            dcBrakeOn <= 1'b0;
            preExciteOn <= 1'b0;
            outFreq <= startF;
            outEnable <= 1'b1;
            timer_reg <= dsTicks(cfg[`DRSS_HOLD_TIME]);
            state_reg <= drss_pkg::ST_HOLD;
          end
        end
        drss_pkg::ST_HOLD: begin
          if (!runCmd && coastMode) begin
            state_reg <= drss_pkg::ST_STOP;
            outEnable <= 1'b0;
            outFreq <= 16'h0000;
          end else if (!runCmd) begin
            state_reg <= drss_pkg::ST_DECEL;
          end else if (timerDone) begin
            state_reg <= drss_pkg::ST_RUN;
          end
        end
        drss_pkg::ST_RUN: begin
          if (!runCmd && coastMode) begin
            state_reg <= drss_pkg::ST_STOP;
            outEnable <= 1'b0;
            outFreq <= 16'h0000;
          end else if (!runCmd) begin
            state_reg <= drss_pkg::ST_DECEL;
          end else if (dirChange && outFreq == 16'h0000) begin
            // reversal restarts at startup frequency with no hold
            outReverse <= revCmd;
            outFreq <= startF;
          end else if (stepNow) begin
            outFreq <= rampUp ? outFreq + 16'h0001 : outFreq - 16'h0001;
          end
        end
        drss_pkg::ST_DECEL: begin
          if (runCmd) begin
            state_reg <= drss_pkg::ST_RUN;
          end else if (coastMode) begin
            state_reg <= drss_pkg::ST_STOP;
            outEnable <= 1'b0;
            outFreq <= 16'h0000;
          end else if (cfg[`DRSS_STOP_TIME] != 16'h0000 && outFreq <= cfg[`DRSS_STOP_FREQ]) begin
            outFreq <= 16'h0000;
            outEnable <= 1'b0;
            timer_reg <= dsTicks(cfg[`DRSS_STOP_WAIT]);
            state_reg <= drss_pkg::ST_WAIT;
          end else if (outFreq == 16'h0000) begin
            outEnable <= 1'b0;
            state_reg <= drss_pkg::ST_STOP;
          end else if (stepNow) begin
            outFreq <= outFreq - 16'h0001;
          end
        end
        drss_pkg::ST_WAIT: begin
          if (timerDone) begin
            dcBrakeOn <= 1'b1;
            dcCurrent <= stopCur[15:0];
            timer_reg <= dsTicks(cfg[`DRSS_STOP_TIME]);
            state_reg <= drss_pkg::ST_STOPDC;
          end
        end
        drss_pkg::ST_STOPDC: begin
          if (timerDone) begin
            dcBrakeOn <= 1'b0;
            state_reg <= drss_pkg::ST_STOP;
          end
        end
        default: begin
          state_reg <= drss_pkg::ST_STOP;
        end
      endcase
    end
  end

  // stage-time flag includes the startup hold; brake duty needs the unit
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      runActive <= 1'b0;
      brakeDuty <= 16'h0000;
    end else if (clkEn) begin
      runActive <= (state_reg == drss_pkg::ST_HOLD) || (state_reg == drss_pkg::ST_RUN);
      brakeDuty <= unitSync ? cfg[`DRSS_BRAKE_USE] : 16'h0000;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      regRdData <= 16'h0000;
    end else if (clkEn) begin
      regRdData <= 16'h0000;
      if (regRd && regAddr <= `DRSS_LAST_CFG) begin
        regRdData <= cfg[regAddr];
      end else if (regRd && regAddr == `DRSS_STATUS) begin
        regRdData <= {standby, runActive, preExciteOn, dcBrakeOn, outReverse, outEnable, 3'h0, state_reg};
      end else if (regRd && regAddr == `DRSS_FREQ_OUT) begin
        regRdData <= outFreq;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/drss_map.svh ====
// register indices, field positions, reset values and timing counts
// assumes a 16-bit register port with a 5-bit word index
`ifndef DRSS_MAP_SVH
`define DRSS_MAP_SVH
`define DRSS_CTRL 5'h00
`define DRSS_TARGET 5'h01
`define DRSS_START_FREQ 5'h02
`define DRSS_HOLD_TIME 5'h03
`define DRSS_START_PCT 5'h04
`define DRSS_START_TIME 5'h05
`define DRSS_STOP_FREQ 5'h06
`define DRSS_STOP_WAIT 5'h07
`define DRSS_STOP_PCT 5'h08
`define DRSS_STOP_TIME 5'h09
`define DRSS_BRAKE_USE 5'h0A
`define DRSS_S_START 5'h0B
`define DRSS_S_END 5'h0C
`define DRSS_MAX_FREQ 5'h0D
`define DRSS_RATED_FREQ 5'h0E
`define DRSS_DEV_CUR 5'h0F
`define DRSS_MOT_CUR 5'h10
`define DRSS_ACC0 5'h11
`define DRSS_DEC0 5'h15
`define DRSS_LAST_CFG 5'h18
`define DRSS_STATUS 5'h19
`define DRSS_FREQ_OUT 5'h1A
`define DRSS_CFG_N 25
// control word fields
`define DRSS_CTRL_RUN 0
`define DRSS_CTRL_REV 1
`define DRSS_CTRL_PREEX 2
`define DRSS_CTRL_COAST 3
`define DRSS_CTRL_RAMP_LO 4
// ramp mode codes
`define DRSS_RAMP_LIN 2'h0
`define DRSS_RAMP_SA 2'h1
`define DRSS_RAMP_SB 2'h2
// reset values (0.01 Hz, 0.1 s, 1 %, 0.1 % units)
`define DRSS_DEF_START_FREQ 16'h0032
`define DRSS_DEF_STOP_PCT 16'h001E
`define DRSS_DEF_BRAKE_USE 16'h0320
`define DRSS_DEF_S_RATIO 16'h012C
`define DRSS_DEF_FREQ 16'h1388
`define DRSS_DEF_CUR 16'h0064
`define DRSS_DEF_RAMP_TIME 16'h0064
// timing: 8 ns clock, 10 ms control tick, 0.1 s setting unit
`define DRSS_CLK_NS 8
`define DRSS_TICK_US 10000
`define DRSS_TICK_CYCLES ((`DRSS_TICK_US * 1000) / `DRSS_CLK_NS)
`define DRSS_TICKS_PER_DS (100000 / `DRSS_TICK_US)
`define DRSS_SLOPE_FULL 9'h100
`endif

// ==== rtl/drss_pkg.sv ====
// types shared by the start/stop ramp sequencer
// assumes the constants header is included by users
package drss_pkg;
  typedef enum logic [6:0] {
    ST_STOP = 7'h01,
    ST_STARTDC = 7'h02,
    ST_HOLD = 7'h04,
    ST_RUN = 7'h08,
    ST_DECEL = 7'h10,
    ST_WAIT = 7'h20,
    ST_STOPDC = 7'h40
  } drss_state_e;
  typedef logic [15:0] drss_word_t;
endpackage

// ==== testbench/drss_seq_asserts.sv ====
// port checker for the start/stop ramp sequencer
// assumes it is bound onto drss_sequencer with clkEn held high
`timescale 1ns/1ns
`default_nettype none
`include "drss_map.svh"
module drss_seq_asserts #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic brakeUnitPin,
  input wire logic [15:0] outFreq,
  input wire logic outEnable,
  input wire logic outReverse,
  input wire logic dcBrakeOn,
  input wire logic preExciteOn,
  input wire logic [15:0] brakeDuty,
  input wire logic standby
);
  logic [15:0] startFreq_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // shadow of the startup frequency so the first driven value can be judged
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      startFreq_reg <= `DRSS_DEF_START_FREQ;
    end else if (clkEn && regWr && regAddr == `DRSS_START_FREQ) begin
      startFreq_reg <= regWrData;
    end
  end
  // coast command and a steady driven stretch in one direction
  sequence coastCmd;
    clkEn && regWr && regAddr == `DRSS_CTRL && !regWrData[`DRSS_CTRL_RUN] && regWrData[`DRSS_CTRL_COAST];
  endsequence
  sequence steadyDrive;
    outEnable && $past(outEnable) && $stable(outReverse);
  endsequence
  start_freq_a: assert property ($rose(outEnable) |-> outFreq == startFreq_reg)
    else $error("drive did not begin at the startup frequency");
  standby_idle_a: assert property (standby |-> !outEnable && outFreq == 16'h0000)
    else $error("standby while driving");
  dc_no_drive_a: assert property (dcBrakeOn |-> !outEnable)
    else $error("dc braking while driving");
  preex_excl_a: assert property (preExciteOn |-> !outEnable && !dcBrakeOn)
    else $error("pre-excitation overlaps drive or braking");
  coast_cut_a: assert property (coastCmd |-> ##[1:3] !outEnable)
    else $error("coast stop did not end the output");
  brake_unit_a: assert property ((!brakeUnitPin) [*5] |-> brakeDuty == 16'h0000)
    else $error("brake usage without braking unit");
  ramp_slope_a: assert property (steadyDrive |-> 16'(outFreq - $past(outFreq) + 16'h0001) <= 16'h0002)
    else $error("frequency stepped more than one unit");
  reset_clear_a: assert property (@(posedge clock) disable iff (1'b0) !rst_b |-> outFreq == 16'h0000 && !outEnable)
    else $error("outputs not cleared in reset");
endmodule
`default_nettype wire

// ==== testbench/drss_motor_model.sv ====
// power stage and motor as seen from the sequencer outputs
// assumes the sequencer clock; speed kept in output frequency units
`timescale 1ns/1ns
`default_nettype none
module drss_motor_model (
  input wire logic clock,
  input wire logic [15:0] outFreq,
  input wire logic outEnable,
  input wire logic dcBrakeOn,
  output logic [15:0] motorSpeed
);
  initial motorSpeed = 16'h0000;
  // shaft follows the drive, spins down freely, dc braking slows it faster
  always @(posedge clock) begin
    if (outEnable) begin
      motorSpeed <= outFreq;
    end else if (dcBrakeOn) begin
      motorSpeed <= (motorSpeed > 16'h0004) ? motorSpeed - 16'h0004 : 16'h0000;
    end else if (motorSpeed != 16'h0000) begin
      motorSpeed <= motorSpeed - 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/drss_sequencer_tb.sv ====
// self-checking bench for the start/stop ramp sequencer
// assumes a 20-cycle control tick so 0.1 s settings last 200 cycles
`timescale 1ns/1ns
`default_nettype none
`include "drss_map.svh"
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errorCnt++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module drss_sequencer_tb;
  localparam int TICK = 20;
  localparam int DS = TICK * 10; // one 0.1 s unit in cycles
  localparam logic [4:0] DEF_ADDR [8] = '{`DRSS_START_FREQ, `DRSS_STOP_PCT, `DRSS_BRAKE_USE, `DRSS_S_START,
    `DRSS_S_END, `DRSS_MAX_FREQ, `DRSS_ACC0, 5'h1F};
  localparam logic [15:0] DEF_VAL [8] = '{16'h0032, 16'h001E, 16'h0320, 16'h012C, 16'h012C, 16'h1388, 16'h0064, 16'h0000};
  logic clock = 1'b0;
  logic rst_b = 1'b1;
  logic clkEn = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [1:0] rampSelPin = 2'h0;
  logic brakeUnitPin = 1'b0;
  logic [15:0] regRdData, outFreq, dcCurrent, brakeDuty, motorSpeed, rdVal, lastF;
  logic outEnable, outReverse, dcBrakeOn, preExciteOn, standby, runActive;
  int errorCnt = 0;
  int nCompared = 0;
  int n;
  drss_sequencer #(.TICK_CYCLES(TICK)) drss_sequencer_inst (.clock(clock), .rst_b(rst_b), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .rampSelPin(rampSelPin), .brakeUnitPin(brakeUnitPin), .outFreq(outFreq), .outEnable(outEnable),
    .outReverse(outReverse), .dcBrakeOn(dcBrakeOn), .preExciteOn(preExciteOn), .dcCurrent(dcCurrent),
    .brakeDuty(brakeDuty), .standby(standby), .runActive(runActive));
  drss_motor_model drss_motor_model_inst (.clock(clock), .outFreq(outFreq), .outEnable(outEnable),
    .dcBrakeOn(dcBrakeOn), .motorSpeed(motorSpeed));
  always #4 clock = ~clock;
  // write strobe then one idle edge, so the strobe never rises twice at once
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdData;
    @(posedge clock);
  endtask
  // bounded waits; counts are cycles until the level or value appears
  task automatic waitLvl(ref logic s, input logic v, input int lim, output int c);
    c = 0;
    #1;
    while (s !== v && c < lim) begin
      @(posedge clock);
      #1 c++;
    end
    `CHK("level reached", 1'b1, c < lim)
    @(posedge clock);
  endtask
  task automatic waitFreq(input logic [15:0] f, input int lim, output int c);
    c = 0;
    #1;
    while (outFreq !== f && c < lim) begin
      @(posedge clock);
      #1 c++;
    end
    `CHK("frequency reached", 1'b1, c < lim)
    @(posedge clock);
  endtask
  task automatic chkIn(input string nm, input int v, input int lo, input int hi);
    `CHK(nm, 1'b1, (v >= lo && v <= hi))
  endtask
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // cut a hang short: the tests need well under 15000 cycles
  initial begin
    repeat (40000) @(posedge clock);
    errorCnt++;
    wrapUp();
  end
  initial begin
    // a real falling edge at time zero so the async resets fire
    rst_b <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    // defaults, plus an unmapped index reading zero
    foreach (DEF_ADDR[i]) begin
      rd(DEF_ADDR[i], rdVal);
      `CHK("default", DEF_VAL[i], rdVal)
    end
    `CHK("duty no unit", 16'h0000, brakeDuty)
    brakeUnitPin <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK("duty default", 16'h0320, brakeDuty)
    wr(`DRSS_BRAKE_USE, 16'h03E8);
    repeat (2) @(posedge clock);
    `CHK("duty set", 16'h03E8, brakeDuty)
    // target below startup frequency stays in standby
    wr(`DRSS_TARGET, 16'h001E);
    wr(`DRSS_CTRL, 16'h0001);
    repeat (4) @(posedge clock);
    `CHK("standby", 1'b1, standby)
    `CHK("standby idle", 1'b0, outEnable)
    wr(`DRSS_CTRL, 16'h0000);
    // direct start: timed dc braking, hold, linear ramp
    wr(`DRSS_START_PCT, 16'h0032);
    wr(`DRSS_START_TIME, 16'h0001);
    wr(`DRSS_HOLD_TIME, 16'h0001);
    wr(`DRSS_TARGET, 16'h0064);
    wr(`DRSS_CTRL, 16'h0001);
    waitLvl(dcBrakeOn, 1'b1, 10, n);
    `CHK("start current", 1'b1, (dcCurrent >= 16'd49 && dcCurrent <= 16'd50))
    waitLvl(dcBrakeOn, 1'b0, 2 * DS, n);
    chkIn("start braking time", n, DS - TICK - 5, DS + 5);
    waitLvl(outEnable, 1'b1, 5, n);
    repeat (DS - 40) @(posedge clock);
    `CHK("hold", 16'h0032, outFreq)
    `CHK("hold is running", 1'b1, runActive)
    waitFreq(16'h0064, 2000, n);
    chkIn("ramp after hold", n + DS - 40, 2 * DS - TICK, 2 * DS + 3 * TICK);
    // second time set from the terminals: half the slope
    wr(`DRSS_ACC0 + 5'h01, 16'h00C8);
    rampSelPin <= 2'h1;
    wr(`DRSS_TARGET, 16'h00C8);
    waitFreq(16'h00C8, 2000, n);
    chkIn("ramp time set", n, 760, 880);
    // decelerate, wait with output off, then stop braking
    wr(`DRSS_STOP_FREQ, 16'h0050);
    wr(`DRSS_STOP_WAIT, 16'h0001);
    wr(`DRSS_STOP_TIME, 16'h0001);
    wr(`DRSS_CTRL, 16'h0000);
    n = 0;
    while (outEnable === 1'b1 && n < 1000) begin
      lastF = outFreq;
      @(posedge clock);
      #1 n++;
    end
    @(posedge clock);
    chkIn("decel time", n, 440, 560);
    `CHK("braking start", 1'b1, (lastF <= 16'h0050 && lastF > 16'h0040))
    waitLvl(dcBrakeOn, 1'b1, 2 * DS, n);
    chkIn("stop wait", n, DS - TICK - 5, DS + 5);
    `CHK("stop current", 1'b1, (dcCurrent >= 16'd29 && dcCurrent <= 16'd30))
    waitLvl(dcBrakeOn, 1'b0, 2 * DS, n);
    chkIn("stop braking time", n, DS - TICK - 5, DS + 5);
    // pre-excitation on device rating, S-curve A, then coast
    wr(`DRSS_DEV_CUR, 16'h00C8);
    wr(`DRSS_START_PCT, 16'h0014);
    wr(`DRSS_CTRL, 16'h0015);
    waitLvl(preExciteOn, 1'b1, 10, n);
    `CHK("preexcite current", 1'b1, (dcCurrent >= 16'd39 && dcCurrent <= 16'd40))
    waitLvl(preExciteOn, 1'b0, 2 * DS, n);
    chkIn("preexcite time", n, DS - TICK - 5, DS + 5);
    waitLvl(outEnable, 1'b1, 5, n);
    repeat (2 * DS) @(posedge clock);
    wr(`DRSS_CTRL, 16'h0018);
    // output drops at the edge wr returns on; look one edge later
    @(posedge clock);
    `CHK("coast off", 1'b0, outEnable)
    `CHK("motor spins on", 1'b1, (motorSpeed !== 16'h0000))
    // zero start time, S-curve B, reversal without hold, plain stop
    wr(`DRSS_START_TIME, 16'h0000);
    wr(`DRSS_STOP_TIME, 16'h0000);
    wr(`DRSS_TARGET, 16'h0064);
    wr(`DRSS_CTRL, 16'h0021);
    waitLvl(outEnable, 1'b1, 4, n);
    `CHK("no start braking", 1'b0, dcBrakeOn)
    waitFreq(16'h0064, 1500, n);
    wr(`DRSS_CTRL, 16'h0023);
    waitLvl(outReverse, 1'b1, 1500, n);
    repeat (3 * TICK) @(posedge clock);
    `CHK("reversal no hold", 1'b1, (outEnable && outFreq > 16'h0032))
    wr(`DRSS_CTRL, 16'h0022);
    waitLvl(outEnable, 1'b0, 2000, n);
    `CHK("stopped at zero", 16'h0000, outFreq)
    `CHK("no stop braking", 1'b0, dcBrakeOn)
    // clock enable low: a run write must not land or start anything
    clkEn <= 1'b0;
    wr(`DRSS_CTRL, 16'h0001);
    repeat (2) @(posedge clock);
    `CHK("frozen", 1'b0, outEnable)
    clkEn <= 1'b1;
    wrapUp();
  end
endmodule
bind drss_sequencer drss_seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) drss_seq_asserts_inst (.clock(clock),
  .rst_b(rst_b), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .brakeUnitPin(brakeUnitPin), .outFreq(outFreq), .outEnable(outEnable), .outReverse(outReverse),
  .dcBrakeOn(dcBrakeOn), .preExciteOn(preExciteOn), .brakeDuty(brakeDuty), .standby(standby));
`default_nettype wire
